// ===== common/mssc_regs.svh
// Constants for the module serial select and configuration block.
// Assumes inclusion by bare name from the design files.
`ifndef MSSC_REGS_SVH
`define MSSC_REGS_SVH
`define SLOT_SEL_BITS 16
`define SLOT_NUM_LSB 0
`define SLOT_NUM_BITS 8
`define CHASSIS_NUM_LSB 8
`define CHASSIS_NUM_BITS 8
`define ID_BITS 32
`define ID_CNT_BITS 6
`define CFG_BITS 24
`define CHASSIS_ADDR_DEFAULT 8'h00
`define SYNC_STAGES 3
`endif

// ===== common/mssc_pkg.sv
// Types shared by the module serial select and configuration block.
// Assumes the constants header is compiled alongside.
package mssc_pkg;
  typedef enum logic [1:0] {LINK_IDLE, LINK_SELECT, LINK_MODULE} link_state_e;
endpackage : mssc_pkg

// ===== rtl/edge_sync.sv
// Three-flop synchroniser with agreement filter and rising-edge pulse.
// Assumes the input is asynchronous to clk_in.
`timescale 1ns/1ps
`include "mssc_regs.svh"
module edge_sync
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Asynchronous level
  input wire logic async_in,
  // Filtered level and its rising edge
  output logic level_out,
  output logic rise_out
);
  logic [`SYNC_STAGES-1:0] sync_reg;
  logic level_reg;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      sync_reg <= '0;
    end
    else
    begin
      sync_reg <= {sync_reg[`SYNC_STAGES-2:0], async_in};
    end
  end

  // A change counts only once the second and third stages agree.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      level_reg <= 1'b0;
    end
    else if (sync_reg[1] == sync_reg[2])
    begin
      level_reg <= sync_reg[2];
    end
  end

  assign level_out = level_reg;
  assign rise_out = sync_reg[1] & sync_reg[2] & ~level_reg;
endmodule : edge_sync

// ===== rtl/module_serial_select_and_config.sv
// Serial select, configuration and identification logic of one module slot.
// Assumes the serial master drives the shift clock, which idles high and
// may stop between frames; the scan step clock is asynchronous.
`timescale 1ns/1ps
`include "mssc_regs.svh"
module module_serial_select_and_config
  import mssc_pkg::*;
#(
  parameter logic [`SLOT_NUM_BITS-1:0] MY_SLOT = 8'h01,
  parameter logic [`ID_BITS-1:0] MODULE_ID = 32'h0000_1234, // Arbitrary value.
  parameter int CHANNEL_BITS = 5
)
(
  // System clock and reset
  input wire logic ref_clk_in,
  input wire logic srst_in,
  // Link clock from the master
  input wire logic serial_shift_clock_in,
  // Link data and control, sampled on the link clock
  input wire logic serial_in_line_in,
  input wire logic data_addr_flag_in,
  input wire logic selector_load_n_in,
  // Chassis configuration
  input wire logic multi_chassis_in,
  input wire logic [`CHASSIS_NUM_BITS-1:0] chassis_addr_in,
  // Serial output pin
  output logic serial_out_line_out,
  output logic serial_out_line_oe_out,
  // Scan stepping, asynchronous
  input wire logic scan_step_clock_in,
  // System-side results
  output logic module_select_out,
  output logic [`CFG_BITS-1:0] config_out,
  output logic [`SLOT_SEL_BITS-1:0] scan_program_out,
  output logic scan_program_stb_out,
  output logic [CHANNEL_BITS-1:0] channel_counter_out
);
  // Link domain. The link clock may stop, so the select line itself is
  // decided from the load line level plus latched slot value, both settled.
  logic [`SLOT_SEL_BITS-1:0] sel_shift_reg;
  logic [`CFG_BITS-1:0] cfg_shift_reg;
  logic [`ID_BITS-1:0] id_shift_reg;
  logic [`ID_CNT_BITS-1:0] id_count_reg;
  logic cfg_toggle_reg;
  logic id_out_reg;

  // System domain.
  link_state_e state_reg;
  logic select_reg;
  logic [`SLOT_SEL_BITS-1:0] sel_value_reg;
  logic [`CFG_BITS-1:0] config_reg;
  logic scan_stb_reg;
  logic [CHANNEL_BITS-1:0] channel_counter_reg;
  logic load_level;
  logic load_rise;
  logic load_fall;
  logic load_prev_reg;
  logic scan_rise;
  logic [2:0] cfg_tog_sync_reg;
  logic sel_match;
  logic [`SLOT_NUM_BITS-1:0] slot_field;
  logic [`CHASSIS_NUM_BITS-1:0] chassis_field;
  logic link_module_rst;
  logic cfg_take;
  logic cfg_word_seen;
  logic slot_match;
  logic chassis_match;
  logic id_more;
  logic id_out_next;
  logic [`ID_BITS-1:0] id_shift_next;
  logic [`ID_CNT_BITS-1:0] id_count_next;
  logic [CHANNEL_BITS-1:0] channel_counter_next;

  // Reset of the identification shifter and configuration toggle while unselected; it comes
  // from a system flop, so the link side sees it as a level.
  assign link_module_rst = ~select_reg;

  // Bits are taken on the rising edge that ends each low pulse.
  always_ff @(posedge serial_shift_clock_in)
  begin
    if (!selector_load_n_in)
    begin
      sel_shift_reg <= {sel_shift_reg[`SLOT_SEL_BITS-2:0], serial_in_line_in};
    end
  end

  assign cfg_take = selector_load_n_in && select_reg && !data_addr_flag_in;

  always_ff @(posedge serial_shift_clock_in)
  begin
    if (cfg_take)
    begin
      cfg_shift_reg <= {cfg_shift_reg[`CFG_BITS-2:0], serial_in_line_in};
    end
  end

  // The toggle must start from a known level, or the system side never sees
  // a defined change. It clears while unselected, which at most reloads the
  // unchanged shifter contents into the configuration word.
  always_ff @(posedge serial_shift_clock_in or posedge link_module_rst)
  begin
    if (link_module_rst)
    begin
      cfg_toggle_reg <= 1'b0;
    end
    else if (cfg_take)
    begin
      cfg_toggle_reg <= ~cfg_toggle_reg;
    end
  end

  // Bits past the end of the register read as zero until the next reload.
  assign id_more = (id_count_reg < `ID_BITS);

  always_comb
  begin
    id_out_next = 1'b0;
    id_shift_next = {id_shift_reg[`ID_BITS-2:0], 1'b0};
    id_count_next = id_count_reg;
    if (id_more)
    begin
      id_out_next = id_shift_reg[`ID_BITS-1];
      id_count_next = id_count_reg + 1'b1;
    end
  end

  // The identification register reloads whenever the module is unselected.
  always_ff @(posedge serial_shift_clock_in or posedge link_module_rst)
  begin
    if (link_module_rst)
    begin
      id_shift_reg <= MODULE_ID;
      id_count_reg <= '0;
      id_out_reg <= 1'b0;
    end
    else if (selector_load_n_in && data_addr_flag_in)
    begin
      id_out_reg <= id_out_next;
      id_shift_reg <= id_shift_next;
      id_count_reg <= id_count_next;
    end
  end

  assign serial_out_line_out = id_out_reg;
  assign serial_out_line_oe_out = select_reg;

  // Load line passes the synchroniser.
  edge_sync load_sync
  (
    .clk_in(ref_clk_in),
    .srst_in(srst_in),
    .async_in(selector_load_n_in),
    .level_out(load_level),
    .rise_out()
  );

  edge_sync scan_sync
  (
    .clk_in(ref_clk_in),
    .srst_in(srst_in),
    .async_in(scan_step_clock_in),
    .level_out(),
    .rise_out(scan_rise)
  );

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      // Starts low: the synchronised load level also starts low, so its climb
      // to the idle-high level reads as a rise, which the idle state ignores.
      load_prev_reg <= 1'b0;
    end
    else
    begin
      load_prev_reg <= load_level;
    end
  end

  assign load_rise = load_level & ~load_prev_reg;
  assign load_fall = ~load_level & load_prev_reg;

  // The shifted slot value is quiet once the load line is high, so it is
  // safe to capture it on the synchronised rise, a few system cycles after the line goes high.
  assign slot_field = sel_shift_reg[`SLOT_NUM_LSB +: `SLOT_NUM_BITS];
  assign chassis_field = sel_shift_reg[`CHASSIS_NUM_LSB +: `CHASSIS_NUM_BITS];
  assign slot_match = (slot_field == MY_SLOT);
  // A single-chassis enclosure ignores the chassis byte altogether.
  assign chassis_match = !multi_chassis_in || (chassis_field == chassis_addr_in);
  assign sel_match = slot_match && chassis_match;

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      state_reg <= LINK_IDLE;
      select_reg <= 1'b0;
      sel_value_reg <= '0;
      scan_stb_reg <= 1'b0;
    end
    else
    begin
      scan_stb_reg <= 1'b0;
      case (state_reg)
        LINK_IDLE:
        begin
          if (load_fall)
          begin
            state_reg <= LINK_SELECT;
          end
        end
        LINK_SELECT:
        begin
          select_reg <= 1'b0;
          if (load_rise)
          begin
            sel_value_reg <= sel_shift_reg;
            scan_stb_reg <= 1'b1;
            select_reg <= sel_match;
            state_reg <= LINK_MODULE;
          end
        end
        LINK_MODULE:
        begin
          if (load_fall)
          begin
            select_reg <= 1'b0;
            state_reg <= LINK_SELECT;
          end
        end
        default:
        begin
          state_reg <= LINK_IDLE;
          select_reg <= 1'b0;
        end
      endcase
    end
  end

  // Shifter contents cross by a toggle that flips on every configuration bit shifted in; the shifter is stable once the
  // toggle is seen because the next bit needs a further link clock.
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      cfg_tog_sync_reg <= '0;
      config_reg <= '0;
    end
    else
    begin
      cfg_tog_sync_reg <= {cfg_tog_sync_reg[1:0], cfg_toggle_reg};
      if (cfg_word_seen)
      begin
        config_reg <= cfg_shift_reg;
      end
    end
  end

  assign cfg_word_seen = (cfg_tog_sync_reg[2] != cfg_tog_sync_reg[1]);

  // The counter wraps silently; a scan list longer than it is the master's concern.
  assign channel_counter_next = channel_counter_reg + 1'b1;

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      channel_counter_reg <= '0;
    end
    else if (scan_rise)
    begin
      channel_counter_reg <= channel_counter_next;
    end
  end

  assign module_select_out = select_reg;
  assign config_out = config_reg;
  assign scan_program_out = sel_value_reg;
  assign scan_program_stb_out = scan_stb_reg;
  assign channel_counter_out = channel_counter_reg;
endmodule : module_serial_select_and_config

// ===== bench/mssc_asserts.sv
// Port checks for the module serial select and configuration block.
// Assumes the system clock and synchronous reset; link inputs are async.
`timescale 1ns/1ps
`include "mssc_regs.svh"
module mssc_asserts
#(
  parameter logic [`SLOT_NUM_BITS-1:0] MY_SLOT = 8'h01,
  parameter int CHANNEL_BITS = 5
)
(
  // Watched ports
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic selector_load_n_in,
  input wire logic multi_chassis_in,
  input wire logic [`CHASSIS_NUM_BITS-1:0] chassis_addr_in,
  input wire logic serial_out_line_out,
  input wire logic serial_out_line_oe_out,
  input wire logic module_select_out,
  input wire logic [`CFG_BITS-1:0] config_out,
  input wire logic [`SLOT_SEL_BITS-1:0] scan_program_out,
  input wire logic scan_program_stb_out,
  input wire logic [CHANNEL_BITS-1:0] channel_counter_out
);
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (srst_in);
  chk_load_deselect: assert property (!selector_load_n_in [*7] |-> !module_select_out)
    else $error("select high with load line low");
  chk_select_settle: assert property ($rose(module_select_out) |->
    selector_load_n_in && $past(selector_load_n_in, 3))
    else $error("select rose too early");
  chk_strobe_pulse: assert property (scan_program_stb_out |=> !scan_program_stb_out)
    else $error("strobe longer than one cycle");
  chk_strobe_load: assert property (scan_program_stb_out |-> selector_load_n_in)
    else $error("strobe while load line low");
  chk_chassis_match: assert property ($rose(module_select_out) && multi_chassis_in |->
    ##2 scan_program_out[15:8] == chassis_addr_in)
    else $error("selected with wrong chassis");
  chk_slot_match: assert property ($rose(module_select_out) |->
    ##2 scan_program_out[7:0] == MY_SLOT)
    else $error("selected with wrong slot");
  chk_oe_unsel: assert property (!module_select_out [*2] |->
    !serial_out_line_oe_out && !serial_out_line_out)
    else $error("output driven while unselected");
  chk_config_sel: assert property ($changed(config_out) |->
    module_select_out || $past(module_select_out, 2))
    else $error("config changed while unselected");
  chk_counter_step: assert property ($changed(channel_counter_out) |->
    channel_counter_out == CHANNEL_BITS'($past(channel_counter_out) + 1))
    else $error("counter did not step by one");
endmodule : mssc_asserts
bind module_serial_select_and_config mssc_asserts #(.MY_SLOT(MY_SLOT),
  .CHANNEL_BITS(CHANNEL_BITS)) mssc_asserts_inst (.ref_clk_in(ref_clk_in),
  .srst_in(srst_in), .selector_load_n_in(selector_load_n_in),
  .multi_chassis_in(multi_chassis_in), .chassis_addr_in(chassis_addr_in),
  .serial_out_line_out(serial_out_line_out),
  .serial_out_line_oe_out(serial_out_line_oe_out), .module_select_out(module_select_out),
  .config_out(config_out), .scan_program_out(scan_program_out),
  .scan_program_stb_out(scan_program_stb_out), .channel_counter_out(channel_counter_out));

// ===== bench/master_model.sv
// Serial master model driving the link lines of the module.
// Assumes a 40 ns system clock; bits are spaced 335 ns apart, just over 8 system cycles.
`timescale 1ns/1ps
module master_model
(
  // Link lines
  output logic sclk_out,
  output logic sdi_out,
  output logic flag_out,
  output logic load_n_out,
  input wire logic sdo_in
);
  initial
  begin
    sclk_out = 1'b1;
    sdi_out = 1'b0;
    flag_out = 1'b0;
    load_n_out = 1'b1;
  end
  // The clock stands high between bits so the system side sees every one.
  task automatic shift(input int n, input logic [31:0] v, output logic [31:0] r);
    r = 32'h0000_0000;
    for (int i = 31; i > 31 - n; i--)
    begin
      sdi_out = v[i];
      #7.5 sclk_out = 1'b0;
      #7.5 sclk_out = 1'b1;
      #5 r[i] = sdo_in;
      #315;
    end
  endtask : shift
  task automatic select(input logic [15:0] w);
    logic [31:0] r;
    load_n_out = 1'b0;
    #320;
    shift(16, {w, 16'h0000}, r);
    load_n_out = 1'b1;
    #320;
  endtask : select
endmodule : master_model

// ===== bench/tb.sv
// Self-checking bench for the module serial select and configuration block.
// Assumes the master model drives the link and the checker is bound in.
`timescale 1ns/1ps
`include "mssc_regs.svh"
module tb;
  typedef struct {logic m; logic [7:0] a; logic [15:0] w; logic s;} row_s;
  localparam logic [31:0] ID = 32'h0000_1234; // Arbitrary value.
  row_s rows[6] = '{'{0, 8'h00, 16'h0901, 1}, '{1, 8'h09, 16'h0901, 1},
    '{1, 8'h00, 16'h0901, 0}, '{0, 8'h00, 16'h0000, 0}, '{0, 8'h00, 16'h0002, 0},
    '{1, 8'h00, 16'h0001, 1}};
  logic ref_clk, srst, mc, scan, so, oe, sel, stb, sclk, sdi, flag, load_n;
  logic [7:0] ca;
  logic [23:0] cfg;
  logic [15:0] prog;
  logic [4:0] cnt;
  logic [31:0] r;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  wire sdo = oe ? so : 1'b1;
  module_serial_select_and_config #(.MODULE_ID(ID)) module_serial_select_and_config_inst (
    .ref_clk_in(ref_clk), .srst_in(srst), .serial_shift_clock_in(sclk),
    .serial_in_line_in(sdi), .data_addr_flag_in(flag), .selector_load_n_in(load_n),
    .multi_chassis_in(mc), .chassis_addr_in(ca), .serial_out_line_out(so),
    .serial_out_line_oe_out(oe), .scan_step_clock_in(scan), .module_select_out(sel),
    .config_out(cfg), .scan_program_out(prog), .scan_program_stb_out(stb),
    .channel_counter_out(cnt));
  master_model master_model_inst (.sclk_out(sclk), .sdi_out(sdi), .flag_out(flag),
    .load_n_out(load_n), .sdo_in(sdo));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // The run needs about 2400 cycles; the ceiling leaves a wide margin.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      failures++;
      end_of_test();
    end
  end
  initial
  begin
    srst = 1'b1;
    mc = 1'b0;
    ca = 8'h00;
    scan = 1'b0;
    repeat (16) @(posedge ref_clk);
    #1 srst = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    check(sel, 0);
    check(cfg, 0);
    check(cnt, 0);
    check(oe, 0);
    $display("reset test done");
    foreach (rows[i])
    begin
      @(posedge ref_clk) #1;
      mc = rows[i].m;
      ca = rows[i].a;
      master_model_inst.select(rows[i].w);
      check(sel, rows[i].s);
      check(prog, rows[i].w);
      $display("row %0d done", i);
    end
    master_model_inst.shift(24, 32'h129f_0700, r);
    check(cfg, 24'h12_9f07);
    master_model_inst.flag_out = 1'b1;
    master_model_inst.shift(32, 32'h0000_0000, r);
    check(r, ID);
    master_model_inst.shift(8, 32'hffff_ffff, r);
    check(r[31:24], 8'h00);
    check(cfg, 24'h12_9f07);
    master_model_inst.select(16'h0001);
    master_model_inst.shift(32, 32'h0000_0000, r);
    check(r, ID);
    $display("config and id test done");
    master_model_inst.flag_out = 1'b0;
    master_model_inst.select(16'h0002);
    master_model_inst.shift(24, 32'hffff_ff00, r);
    check(cfg, 24'h12_9f07);
    check(oe, 0);
    repeat (3)
    begin
      @(posedge ref_clk) #1 scan = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1 scan = 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    repeat (6) @(posedge ref_clk);
    #1;
    check(cnt, 3);
    master_model_inst.select(16'h0000);
    check(sel, 0);
    check(prog, 0);
    $display("unselected and scan test done");
    end_of_test();
  end
endmodule : tb
